// ==== design/ep_status_pkg.sv ====
// constants for the endpoint status and buffer-control command block
// assumes one core clock and an 8-bit command/data port from the microcontroller
package ep_status_pkg;

  localparam int unsigned NUM_EP = 16;

  // command code high nibbles; the low nibble selects the endpoint
  localparam logic [3:0] CMD_HI_STALL    = 4'h4;
  localparam logic [3:0] CMD_HI_STATUS   = 4'h5;
  localparam logic [3:0] CMD_HI_VALIDATE = 4'h6;
  localparam logic [3:0] CMD_HI_CLEAR    = 4'h7;
  localparam logic [3:0] CMD_HI_UNSTALL  = 4'h8;
  localparam logic [7:0] CMD_ACK_SETUP   = 8'hf4;

  // endpoint indices of the two control endpoints
  localparam logic [3:0] EP_CTRL_OUT = 4'h0;
  localparam logic [3:0] EP_CTRL_IN  = 4'h1;

  // status byte layout
  localparam int unsigned BIT_HALTED    = 7;
  localparam int unsigned BIT_FULL1     = 6;
  localparam int unsigned BIT_FULL0     = 5;
  localparam int unsigned BIT_TOGGLE    = 4;
  localparam int unsigned BIT_REPLACED  = 3;
  localparam int unsigned BIT_SETUP     = 2;
  localparam int unsigned BIT_PROCESSOR_BUFFER_SELECT    = 1;
  localparam int unsigned BIT_RESERVED  = 0;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;

  // pin bundle order inside the synchroniser: {wr_n, rd_n, a0, data}
  localparam int unsigned PIN_W         = 11;
  localparam logic [10:0] PIN_IDLE      = 11'h600;

  typedef enum logic [0:0] {
    PORT_IDLE,
    PORT_READ
  } port_state_t;

endpackage

// ==== design/pin_sync.sv ====
// three-stage input synchroniser for the asynchronous command port pins
// assumes pins change without regard to clk; output follows once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned      W         = 1,
  parameter logic [W-1:0]     RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] stable_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_next;

  // per bit: accept a change only when the last two stages match
  always_comb begin
    for (int i = 0; i < W; i++) begin
      stable_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : stable_out[i];
    end
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg     <= RESET_VAL;
      s2_reg     <= RESET_VAL;
      s3_reg     <= RESET_VAL;
      stable_out <= RESET_VAL;
    end else begin
      s1_reg     <= async_in;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_out <= stable_next;
    end
  end

endmodule

// ==== design/ep_status_ctrl.sv ====
// endpoint status byte and buffer-control command logic
// assumes command port pins are asynchronous; packet engine strobes are on clk
//
// Summary of operation
// - status read codes 50h-5Fh return one status byte of the chosen endpoint.
// - status read clears that endpoint's interrupt flag as a side effect.
// - status byte is read-only, resets to zero, bit 0 reserved.
// - bit 7 is stall state; stall sets, unstall and SETUP clear it.
// - bit 6 secondary buffer full, bit 5 primary buffer full.
// - bit 4 gives the data toggle expected for the next packet.
// - bit 3 set when a new setup replaces unacknowledged, unstalled setup data.
// - reading the status clears bit 3 once setup data writing has finished.
// - bit 2 is one while the buffer holds a setup packet.
// - bit 1 shows which buffer the processor accesses, primary or secondary.
// - stall codes 40h-4Fh and unstall codes 80h-8Fh, no data phase.
// - SETUP token unstalls a stalled control endpoint regardless of content.
// - unstall reinitialises the endpoint, flushes buffer, toggle returns to DATA0.
// - validate codes 61h-6Fh mark the chosen IN buffer full for sending.
// - validate and clear swap the processor buffer on double-buffered endpoints.
// - clear codes 70h, 72h-7Fh empty the chosen OUT buffer for new packets.
// - a received OUT packet fills a free buffer; once no buffer is free, later packets get NAK.
// - only stall, unstall and SETUP reception change the stall bit.
// - unacknowledged setup blocks validate and clear on control endpoints until F4h.
`timescale 1ns/1ps
module ep_status_ctrl #(
  parameter logic [15:0] EP_IS_IN    = 16'h0002,
  parameter logic [15:0] EP_IS_DOUBLE = 16'hfffc
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_n_pin,
  input  wire logic        rd_n_pin,
  input  wire logic        a0_pin,
  input  wire logic [7:0]  data_pin_in,
  output logic      [7:0]  data_pin_out,
  output logic             data_pin_oe,
  input  wire logic        setup_token,
  input  wire logic        setup_write_done,
  input  wire logic        out_pkt_done,
  input  wire logic [3:0]  out_pkt_ep,
  input  wire logic        in_pkt_sent,
  input  wire logic [3:0]  in_pkt_ep,
  output logic      [15:0] halted_vec,
  output logic      [15:0] nak_vec,
  output logic      [15:0] toggle_vec,
  output logic      [15:0] int_clear,
  output logic      [15:0] ep_flush,
  output logic             setup_locked
);

  localparam int unsigned N = ep_status_pkg::NUM_EP;

  logic [10:0] pins_stable;
  logic        wr_prev_reg;
  logic        rd_prev_reg;
  logic        wr_n_s;
  logic        rd_n_s;
  logic        a0_s;
  logic [7:0]  code_s;

  // per-endpoint state vectors
  logic [N-1:0] halted_next, full0_reg, full0_next, full1_reg, full1_next;
  logic [N-1:0] tog_next, repl_reg, repl_next, setup_reg, setup_next;
  logic [N-1:0] processor_buffer_select_reg, processor_buffer_select_next, nak_next, intclr_next, flush_next;
  logic         busy_reg, busy_next, lock_next;
  logic [7:0]   dout_next;
  logic         oe_next;

  // command decode and port sequencing
  logic                      wr_rise;
  logic                      rd_fall;
  logic                      cmd_stb;
  logic [3:0]                cmd_hi;
  logic [3:0]                cmd_ep;
  logic [N-1:0]              reinit;
  logic [3:0]                sel_reg;
  logic [3:0]                sel_next;
  ep_status_pkg::port_state_t port_reg;
  ep_status_pkg::port_state_t port_next;
  logic [7:0]                status_byte [N];

  // one-hot endpoint mask, used by the command path and the checks
  function automatic logic [N-1:0] ep_bit(input logic [3:0] ep);
    logic [N-1:0] v;
    v     = '0;
    v[ep] = 1'b1;
    return v;
  endfunction

  // the two control endpoints share the setup lock
  function automatic logic ep_is_ctrl(input logic [3:0] ep);
    return (ep == ep_status_pkg::EP_CTRL_OUT) || (ep == ep_status_pkg::EP_CTRL_IN);
  endfunction

  // an OUT endpoint can take a packet while some buffer is empty
  function automatic logic out_room(input logic f0,
                                    input logic f1,
                                    input logic dbl);
    return !f0 || (dbl && !f1);
  endfunction

  // all port pins share one synchroniser so their relative timing survives
  pin_sync #(
    .W         (ep_status_pkg::PIN_W),
    .RESET_VAL (ep_status_pkg::PIN_IDLE)
  ) sync_pins (
    .clk        (clk),
    .rst_n      (rst_n),
    .async_in   ({wr_n_pin, rd_n_pin, a0_pin, data_pin_in}),
    .stable_out (pins_stable)
  );

  assign {wr_n_s, rd_n_s, a0_s, code_s} = pins_stable;

  // strobe history; idle high so reset gives no false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
    end else begin
      wr_prev_reg <= wr_n_s;
      rd_prev_reg <= rd_n_s;
    end
  end

  // command taken at the end of the write strobe, data long settled
  assign wr_rise = wr_n_s && !wr_prev_reg;
  assign cmd_stb = wr_rise && a0_s;
  assign rd_fall = !rd_n_s && rd_prev_reg && !a0_s;
  assign cmd_hi  = code_s[7:4];
  assign cmd_ep  = code_s[3:0];

  // status byte assembly, bit 0 reserved low
  for (genvar g = 0; g < N; g++) begin : g_status
    assign status_byte[g] = {halted_vec[g], full1_reg[g], full0_reg[g], toggle_vec[g],
                             repl_reg[g], setup_reg[g], processor_buffer_select_reg[g], 1'b0};
  end

  // next state of the endpoint array and the read port
  always_comb begin
    halted_next = halted_vec;
    full0_next  = full0_reg;
    full1_next  = full1_reg;
    tog_next    = toggle_vec;
    repl_next   = repl_reg;
    setup_next  = setup_reg;
    processor_buffer_select_next = processor_buffer_select_reg;
    intclr_next = '0;
    flush_next  = '0;
    busy_next   = busy_reg;
    lock_next   = setup_locked;
    port_next   = port_reg;
    sel_next    = sel_reg;
    dout_next   = data_pin_out;
    oe_next     = data_pin_oe;
    reinit      = '0;

    // one byte, held while the read strobe stays low
    if (rd_fall && port_reg == ep_status_pkg::PORT_READ) begin
      dout_next = status_byte[sel_reg];
      oe_next   = 1'b1;
      port_next = ep_status_pkg::PORT_IDLE;
      // cleared only once setup data is written
      if (!busy_reg) begin
        repl_next[sel_reg] = 1'b0;
      end
    end else if (rd_n_s) begin
      oe_next = 1'b0;
    end

    // received packet fills a buffer, else NAK
    if (out_pkt_done && !EP_IS_IN[out_pkt_ep] && !halted_vec[out_pkt_ep]) begin
      if (!full0_reg[out_pkt_ep]) begin
        full0_next[out_pkt_ep] = 1'b1;
        tog_next[out_pkt_ep]   = !toggle_vec[out_pkt_ep];
      end else if (out_room(full0_reg[out_pkt_ep], full1_reg[out_pkt_ep], EP_IS_DOUBLE[out_pkt_ep])) begin
        full1_next[out_pkt_ep] = 1'b1;
        tog_next[out_pkt_ep]   = !toggle_vec[out_pkt_ep];
      end
    end

    // a sent IN packet frees the primary buffer if full, else the secondary, and flips the toggle
    if (in_pkt_sent && EP_IS_IN[in_pkt_ep] && !halted_vec[in_pkt_ep]) begin
      if (full0_reg[in_pkt_ep]) begin
        full0_next[in_pkt_ep] = 1'b0;
        tog_next[in_pkt_ep]   = !toggle_vec[in_pkt_ep];
      end else if (full1_reg[in_pkt_ep]) begin
        full1_next[in_pkt_ep] = 1'b0;
        tog_next[in_pkt_ep]   = !toggle_vec[in_pkt_ep];
      end
    end

    // SETUP releases a stalled control pair
    if (setup_token) begin
      reinit = (ep_bit(ep_status_pkg::EP_CTRL_OUT) | ep_bit(ep_status_pkg::EP_CTRL_IN)) & halted_vec;
    end
    if (cmd_stb && cmd_hi == ep_status_pkg::CMD_HI_UNSTALL) begin
      reinit = reinit | ep_bit(cmd_ep);
    end

    // reinitialise: flush buffers, toggle back to DATA0
    for (int e = 0; e < N; e++) begin
      if (reinit[e]) begin
        halted_next[e] = 1'b0;
        full0_next[e]  = 1'b0;
        full1_next[e]  = 1'b0;
        tog_next[e]    = 1'b0;
        processor_buffer_select_next[e] = 1'b0;
        setup_next[e]  = 1'b0;
        flush_next[e]  = 1'b1;
      end
    end

    // new setup over unacknowledged data on a live endpoint
    if (setup_token) begin
      if (setup_reg[ep_status_pkg::EP_CTRL_OUT] && setup_locked &&
          !halted_vec[ep_status_pkg::EP_CTRL_OUT]) begin
        repl_next[ep_status_pkg::EP_CTRL_OUT] = 1'b1;
      end
      setup_next[ep_status_pkg::EP_CTRL_OUT] = 1'b1;
      busy_next                              = 1'b1;
      lock_next                              = 1'b1;
    end
    // setup payload complete: buffer counts as full
    if (setup_write_done && busy_reg) begin
      busy_next                              = 1'b0;
      full0_next[ep_status_pkg::EP_CTRL_OUT] = 1'b1;
    end

    // commands act last so they win over same-cycle packet events, except unstall, which acts through reinit before the setup updates
    if (cmd_stb) begin
      case (cmd_hi)
        ep_status_pkg::CMD_HI_STALL: begin
          halted_next[cmd_ep] = 1'b1;
        end
        ep_status_pkg::CMD_HI_UNSTALL: begin
          // applied through the reinit mask above
        end
        // status read clears the interrupt flag
        ep_status_pkg::CMD_HI_STATUS: begin
          intclr_next = ep_bit(cmd_ep);
          port_next   = ep_status_pkg::PORT_READ;
          sel_next    = cmd_ep;
        end
        // validate marks the processor buffer full
        ep_status_pkg::CMD_HI_VALIDATE: begin
          if (EP_IS_IN[cmd_ep] && cmd_ep != ep_status_pkg::EP_CTRL_OUT &&
              !(setup_locked && ep_is_ctrl(cmd_ep))) begin
            if (EP_IS_DOUBLE[cmd_ep] && processor_buffer_select_next[cmd_ep]) begin
              full1_next[cmd_ep] = 1'b1;
            end else begin
              full0_next[cmd_ep] = 1'b1;
            end
            if (EP_IS_DOUBLE[cmd_ep]) begin
              processor_buffer_select_next[cmd_ep] = !processor_buffer_select_next[cmd_ep];
            end
          end
        end
        ep_status_pkg::CMD_HI_CLEAR: begin
          if (!EP_IS_IN[cmd_ep] && cmd_ep != ep_status_pkg::EP_CTRL_IN &&
              !(setup_locked && ep_is_ctrl(cmd_ep))) begin
            if (EP_IS_DOUBLE[cmd_ep] && processor_buffer_select_next[cmd_ep]) begin
              full1_next[cmd_ep] = 1'b0;
            end else begin
              full0_next[cmd_ep] = 1'b0;
            end
            setup_next[cmd_ep] = 1'b0;
            if (EP_IS_DOUBLE[cmd_ep]) begin
              processor_buffer_select_next[cmd_ep] = !processor_buffer_select_next[cmd_ep];
            end
          end
        end
        default: begin
          if (code_s == ep_status_pkg::CMD_ACK_SETUP) begin
            lock_next = 1'b0;
          end
        end
      endcase
    end

    // handshake view for the packet engine; a halted endpoint stalls instead
    for (int e = 0; e < N; e++) begin
      if (EP_IS_IN[e]) begin
        nak_next[e] = !halted_next[e] && !(full0_next[e] || full1_next[e]);
      end else begin
        nak_next[e] = !halted_next[e] && !out_room(full0_next[e], full1_next[e], EP_IS_DOUBLE[e]);
      end
    end
  end

  // every status bit resets to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halted_vec   <= '0;
      full0_reg    <= '0;
      full1_reg    <= '0;
      toggle_vec   <= '0;
      repl_reg     <= '0;
      setup_reg    <= '0;
      processor_buffer_select_reg   <= '0;
      nak_vec      <= EP_IS_IN;
      int_clear    <= '0;
      ep_flush     <= '0;
      busy_reg     <= 1'b0;
      setup_locked <= 1'b0;
      port_reg     <= ep_status_pkg::PORT_IDLE;
      sel_reg      <= 4'h0;
      data_pin_out <= ep_status_pkg::STATUS_RESET;
      data_pin_oe  <= 1'b0;
    end else begin
      halted_vec   <= halted_next;
      full0_reg    <= full0_next;
      full1_reg    <= full1_next;
      toggle_vec   <= tog_next;
      repl_reg     <= repl_next;
      setup_reg    <= setup_next;
      processor_buffer_select_reg   <= processor_buffer_select_next;
      nak_vec      <= nak_next;
      int_clear    <= intclr_next;
      ep_flush     <= flush_next;
      busy_reg     <= busy_next;
      setup_locked <= lock_next;
      port_reg     <= port_next;
      sel_reg      <= sel_next;
      data_pin_out <= dout_next;
      data_pin_oe  <= oe_next;
    end
  end

  // checks on what this block drives
  AST_RESERVED_LOW: assert property (@(posedge clk) disable iff (!rst_n) data_pin_oe |-> !data_pin_out[0])
    else $error("reserved status bit driven high");

  AST_STALL_SETS: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_stb && cmd_hi == ep_status_pkg::CMD_HI_STALL |=> halted_vec[$past(cmd_ep)])
    else $error("stall command did not halt endpoint");

  AST_UNSTALL_REINIT: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_stb && cmd_hi == ep_status_pkg::CMD_HI_UNSTALL |=>
    !halted_vec[$past(cmd_ep)] && !toggle_vec[$past(cmd_ep)] && ep_flush[$past(cmd_ep)])
    else $error("unstall did not reinitialise endpoint");

  AST_HALT_SOURCES: assert property (@(posedge clk) disable iff (!rst_n)
    halted_vec != $past(halted_vec) |->
    $past(setup_token) || $past(cmd_stb && (cmd_hi == ep_status_pkg::CMD_HI_STALL ||
                                            cmd_hi == ep_status_pkg::CMD_HI_UNSTALL)))
    else $error("halted bits changed without a legal source");

  AST_INTCLR_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_stb && cmd_hi == ep_status_pkg::CMD_HI_STATUS |=> int_clear == ep_bit($past(cmd_ep)))
    else $error("status read did not clear interrupt flag");

  AST_REPLACED_SET: assert property (@(posedge clk) disable iff (!rst_n)
    setup_token && setup_reg[0] && setup_locked && !halted_vec[0] |=> repl_reg[0])
    else $error("replaced setup not flagged");

  AST_LOCK_REFUSES: assert property (@(posedge clk) disable iff (!rst_n)
    setup_locked && cmd_stb && cmd_hi == ep_status_pkg::CMD_HI_VALIDATE && cmd_ep == 4'h1 &&
    !in_pkt_sent && !setup_token |=> full0_reg[1] == $past(full0_reg[1]))
    else $error("validate accepted while setup locked");

  // main scenarios reached
  COV_STALL: cover property (@(posedge clk) disable iff (!rst_n) cmd_stb && cmd_hi == ep_status_pkg::CMD_HI_STALL);
  COV_SETUP_LOCKED: cover property (@(posedge clk) disable iff (!rst_n) setup_token && setup_locked);
  COV_STATUS_READ: cover property (@(posedge clk) disable iff (!rst_n) rd_fall && port_reg == ep_status_pkg::PORT_READ);
  COV_OUT_STORED: cover property (@(posedge clk) disable iff (!rst_n) out_pkt_done && !nak_vec[out_pkt_ep]);

endmodule

// ==== sim/mcu_port_model.sv ====
// microcontroller model driving the command port pins
// assumes the bench calls its tasks; pins move on the falling edge
`timescale 1ns/1ps
module mcu_port_model (
  input  wire logic       clk,
  output logic            wr_n_pin,
  output logic            rd_n_pin,
  output logic            a0_pin,
  output logic [7:0]      data_pin_in,
  input  wire logic [7:0] data_pin_out
);
  initial begin
    {wr_n_pin, rd_n_pin, a0_pin, data_pin_in} = 11'h700;
  end
  task automatic cmd(input logic [7:0] code);
    @(negedge clk) a0_pin = 1'b1;
    data_pin_in = code;
    wr_n_pin = 1'b0;
    repeat (6) @(negedge clk);
    wr_n_pin = 1'b1;
    repeat (6) @(negedge clk);
    data_pin_in = ~code;  // released bus must not look held
  endtask
  // one byte, sampled late so the synchroniser has settled
  task automatic rd(output logic [7:0] d);
    @(negedge clk) a0_pin = 1'b0;
    rd_n_pin = 1'b0;
    repeat (8) @(negedge clk);
    d = data_pin_out;
    rd_n_pin = 1'b1;
    a0_pin = 1'b1;
    repeat (6) @(negedge clk);
  endtask
endmodule

// ==== sim/usb_endpoint_status_control_bench.sv ====
// status and command bench for the endpoint status block
// assumes the model above owns the port pins
`timescale 1ns/1ps
module usb_endpoint_status_control_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr_n, rd_n, a0, oe, stok, sdone, opkt, ipkt;
  logic [7:0]  din, dout, rb;
  logic [15:0] halted;
  int          err_count = 0;
  int          checks_done = 0;
  always #4 clk = ~clk;
  ep_status_ctrl dut (.clk(clk), .rst_n(rst_n), .wr_n_pin(wr_n), .rd_n_pin(rd_n), .a0_pin(a0),
    .data_pin_in(din), .data_pin_out(dout), .data_pin_oe(oe), .setup_token(stok),
    .setup_write_done(sdone), .out_pkt_done(opkt), .out_pkt_ep(4'h2), .in_pkt_sent(ipkt),
    .in_pkt_ep(4'h1), .halted_vec(halted), .nak_vec(), .toggle_vec(), .int_clear(),
    .ep_flush(), .setup_locked());
  mcu_port_model mcu (.clk(clk), .wr_n_pin(wr_n), .rd_n_pin(rd_n), .a0_pin(a0),
    .data_pin_in(din), .data_pin_out(dout));
  // status command then one read, compared
  task automatic chk(input logic [7:0] code, input logic [7:0] exp);
    mcu.cmd(code);
    mcu.rd(rb);
    checks_done++;
    if (rb !== exp) begin
      err_count++;
      $display("ERROR %0t status %h read %h", $time, code, rb);
    end
  endtask
  // setup token followed by the end of its data write
  task automatic pulse_setup;
    @(negedge clk) stok = 1'b1;
    @(negedge clk) stok = 1'b0;
    repeat (2) @(negedge clk);
    sdone = 1'b1;
    @(negedge clk) sdone = 1'b0;
  endtask
  task automatic end_sim;
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    {stok, sdone, opkt, ipkt} = 4'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(8'h52, 8'h00);
    mcu.cmd(8'h43);
    chk(8'h53, 8'h80);
    checks_done++;
    if (halted[3] !== 1'b1) begin
      err_count++;
      $display("ERROR %0t halt line low", $time);
    end
    mcu.cmd(8'h83);
    mcu.cmd(8'h83);
    chk(8'h53, 8'h00);
    @(negedge clk) opkt = 1'b1;
    @(negedge clk) opkt = 1'b0;
    chk(8'h52, 8'h30);
    mcu.cmd(8'h72);
    chk(8'h52, 8'h12);
    mcu.cmd(8'h40);
    chk(8'h50, 8'h80);
    pulse_setup;
    chk(8'h50, 8'h24);
    pulse_setup;
    chk(8'h50, 8'h2c);
    chk(8'h50, 8'h24);
    mcu.cmd(8'h61);
    chk(8'h51, 8'h00);
    mcu.cmd(8'hf4);
    mcu.cmd(8'h61);
    chk(8'h51, 8'h20);
    @(negedge clk) ipkt = 1'b1;
    @(negedge clk) ipkt = 1'b0;
    chk(8'h51, 8'h10);
    mcu.cmd(8'h40);
    chk(8'h50, 8'ha4);
    end_sim;
  end
  // hang guard, far beyond the expected run time
  initial begin
    #50000;
    err_count++;
    end_sim;
  end
endmodule
